// [src/aumu_unit.sv]
// Atomic unsigned min/max decode and execute unit with APB registers
`timescale 1ns/1ps
module aumu_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    output logic instr_ready,
    output logic [4:0] rd_src_sel,
    output logic [4:0] rd_base_sel,
    input wire logic [63:0] src_value,
    input wire logic [63:0] base_value,
    input wire logic [63:0] stack_ptr,
    output logic mem_valid,
    output logic mem_write,
    output logic mem_lock,
    output logic [63:0] mem_addr,
    output logic [1:0] mem_size,
    output logic [63:0] mem_wdata,
    output logic [63:0] mem_compare,
    output logic mem_acquire,
    output logic mem_release,
    output logic mem_tagchecked,
    output logic mem_op_max,
    input wire logic mem_ready,
    input wire logic mem_rvalid,
    input wire logic [63:0] mem_rdata,
    output logic wb_valid,
    output logic [4:0] wb_dest,
    output logic [63:0] wb_data,
    output logic wb_is64,
    output logic sp_check,
    output logic undef_instr,
    output logic irq
);
    import aumu_pkg::*;

    typedef struct packed {
        aumu_state_type state;
        logic instr_ready;
        logic [4:0] dest;
        logic [4:0] base_f;
        logic [1:0] size;
        logic acq;
        logic rel;
        logic is_max;
        logic [63:0] value;
        logic [63:0] data;
        logic [4:0] rd_src;
        logic [4:0] rd_base;
        logic mem_valid;
        logic mem_write;
        logic mem_lock;
        logic [63:0] mem_addr;
        logic [1:0] mem_size;
        logic [63:0] mem_wdata;
        logic [63:0] mem_compare;
        logic mem_acquire;
        logic mem_release;
        logic mem_tag;
        logic mem_op_max;
        logic wb_valid;
        logic [4:0] wb_dest;
        logic [63:0] wb_data;
        logic wb_is64;
        logic sp_check;
        logic undef;
        logic ctrl_feat;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic [31:0] op_count;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } aumu_regs_type;

    aumu_regs_type q;
    aumu_regs_type next_q;

    logic [2:0] events;
    logic [1:0] dec_size;
    logic [2:0] dec_opc;
    logic [4:0] dec_dest;
    logic dec_legal;
    logic [63:0] rd_masked;
    logic [63:0] new_value;
    logic apb_done;
    // Acquire expected on the read, followed by a_acq_read
    logic acq_want;

    always_comb begin
        dec_size = instr_word[SIZE_LO +: 2];
        dec_opc = instr_word[OPC_LO +: 3];
        dec_dest = instr_word[DEST_LO +: 5];
        acq_want = instr_word[ACQ_POS] && (dec_dest != ZERO_REG);
        // Fixed bits, opcode and the one maximum form kept here
        dec_legal = (instr_word[29:24] == FIXED_29_24) && instr_word[ONE_POS]
            && !instr_word[ZERO_POS] && (instr_word[11:10] == FIXED_11_10)
            && ((dec_opc == OPC_MIN) || ((dec_opc == OPC_MAX) && (dec_size == SIZE_HALF)));
        rd_masked = mem_rdata & aumu_width_mask(q.size);
        // Unsigned compare at the operand width
        if (q.is_max) begin
            new_value = (rd_masked > q.value) ? rd_masked : q.value;
        end else begin
            new_value = (rd_masked < q.value) ? rd_masked : q.value;
        end
        apb_done = psel && penable && q.pready;
    end

    always_comb begin
        next_q = q;
        events = 3'h0;
        next_q.wb_valid = 1'b0;
        next_q.sp_check = 1'b0;
        next_q.undef = 1'b0;
        next_q.mem_compare = 64'h0;
        case (q.state)
            ST_IDLE: begin
                if (instr_valid && q.instr_ready) begin
                    if (!q.ctrl_feat || !dec_legal) begin
                        next_q.undef = 1'b1;
                        events[EV_UNDEF_POS] = 1'b1;
                    end else begin
                        next_q.instr_ready = 1'b0;
                        next_q.size = dec_size;
                        next_q.dest = dec_dest;
                        next_q.base_f = instr_word[BASE_LO +: 5];
                        next_q.acq = instr_word[ACQ_POS] && (dec_dest != ZERO_REG);
                        next_q.rel = instr_word[REL_POS];
                        next_q.is_max = (dec_opc == OPC_MAX);
                        next_q.rd_src = instr_word[SRC_LO +: 5];
                        next_q.rd_base = instr_word[BASE_LO +: 5];
                        next_q.state = ST_FETCH;
                    end
                end
            end
            ST_FETCH: begin
                // Operands arrive one cycle after the register selects
                next_q.value = src_value & aumu_width_mask(q.size);
                if (q.base_f == ZERO_REG) begin
                    next_q.mem_addr = stack_ptr;
                    next_q.sp_check = 1'b1;
                    events[EV_SPCHK_POS] = 1'b1;
                end else begin
                    next_q.mem_addr = base_value;
                end
                next_q.mem_tag = (q.base_f != ZERO_REG);
                next_q.mem_size = q.size;
                next_q.mem_op_max = q.is_max;
                next_q.mem_valid = 1'b1;
                next_q.mem_write = 1'b0;
                next_q.mem_lock = 1'b1;
                next_q.mem_acquire = q.acq;
                next_q.mem_release = 1'b0;
                next_q.state = ST_READ;
            end
            ST_READ: begin
                if (mem_ready) begin
                    next_q.mem_valid = 1'b0;
                    next_q.state = ST_RWAIT;
                end
            end
            ST_RWAIT: begin
                if (mem_rvalid) begin
                    next_q.data = rd_masked;
                    next_q.mem_wdata = new_value;
                    next_q.mem_valid = 1'b1;
                    next_q.mem_write = 1'b1;
                    next_q.mem_acquire = 1'b0;
                    next_q.mem_release = q.rel;
                    next_q.state = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (mem_ready) begin
                    next_q.mem_valid = 1'b0;
                    next_q.mem_write = 1'b0;
                    next_q.mem_lock = 1'b0;
                    next_q.mem_release = 1'b0;
                    // Destination 31 gets nothing, store-only forms included
                    next_q.wb_valid = (q.dest != ZERO_REG);
                    next_q.wb_dest = q.dest;
                    next_q.wb_data = q.data;
                    next_q.wb_is64 = (q.size == SIZE_DWORD);
                    next_q.op_count = q.op_count + 32'h1;
                    events[EV_DONE_POS] = 1'b1;
                    next_q.instr_ready = 1'b1;
                    next_q.state = ST_IDLE;
                end
            end
            default: begin
                next_q.state = ST_IDLE;
                next_q.instr_ready = 1'b1;
            end
        endcase

        // APB slave with one wait state
        next_q.pready = psel && penable && !q.pready;
        next_q.pslverr = 1'b0;
        if (psel && penable && !q.pready) begin
            case (paddr)
                REG_CTRL: next_q.prdata = {31'h0, q.ctrl_feat};
                REG_STATUS: next_q.prdata = {27'h0, q.size, q.state};
                REG_IRQ_STATUS: next_q.prdata = {29'h0, q.irq_status};
                REG_IRQ_MASK: next_q.prdata = {29'h0, q.irq_mask};
                REG_OP_COUNT: next_q.prdata = q.op_count;
                default: begin
                    next_q.prdata = 32'h0;
                    next_q.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_done && pwrite) begin
            case (paddr)
                REG_CTRL: next_q.ctrl_feat = pwdata[CTRL_FEAT_POS];
                REG_IRQ_MASK: next_q.irq_mask = pwdata[2:0];
                default: begin
                end
            endcase
        end
        // Read clears the sticky bits; a new event in that cycle survives
        if (apb_done && !pwrite && (paddr == REG_IRQ_STATUS)) begin
            next_q.irq_status = events;
        end else begin
            next_q.irq_status = q.irq_status | events;
        end
        next_q.irq = |(next_q.irq_status & next_q.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.state <= ST_IDLE;
            q.instr_ready <= 1'b1;
            q.ctrl_feat <= CTRL_FEAT_RESET;
            q.irq_mask <= IRQ_MASK_RESET;
        end else if (clk_en) begin
            q <= next_q;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign instr_ready = q.instr_ready;
    assign rd_src_sel = q.rd_src;
    assign rd_base_sel = q.rd_base;
    assign mem_valid = q.mem_valid;
    assign mem_write = q.mem_write;
    assign mem_lock = q.mem_lock;
    assign mem_addr = q.mem_addr;
    assign mem_size = q.mem_size;
    assign mem_wdata = q.mem_wdata;
    assign mem_compare = q.mem_compare;
    assign mem_acquire = q.mem_acquire;
    assign mem_release = q.mem_release;
    assign mem_tagchecked = q.mem_tag;
    assign mem_op_max = q.mem_op_max;
    assign wb_valid = q.wb_valid;
    assign wb_dest = q.wb_dest;
    assign wb_data = q.wb_data;
    assign wb_is64 = q.wb_is64;
    assign sp_check = q.sp_check;
    assign undef_instr = q.undef;
    assign irq = q.irq;

    a_min_store: assert property (
        @(posedge pclk iff clk_en) disable iff (!presetn)
        (q.state == ST_RWAIT && mem_rvalid && !q.is_max)
        |=> (mem_write && mem_valid && mem_wdata ==
            (($past(rd_masked) < $past(q.value)) ? $past(rd_masked) : $past(q.value))))
        else $error("minimum write-back value wrong");

    a_max_store: assert property (
        @(posedge pclk iff clk_en) disable iff (!presetn)
        (q.state == ST_RWAIT && mem_rvalid && q.is_max)
        |=> (mem_write && mem_wdata ==
            (($past(rd_masked) > $past(q.value)) ? $past(rd_masked) : $past(q.value))))
        else $error("maximum write-back value wrong");

    a_result_orig: assert property (
        @(posedge pclk iff clk_en) disable iff (!presetn)
        (q.state == ST_WRITE && mem_ready) |=> (wb_valid == (q.dest != 5'h1F)
            && wb_data == $past(q.data)))
        else $error("result is not the original memory value");

    a_acq_read: assert property (
        @(posedge pclk iff clk_en) disable iff (!presetn)
        (q.state == ST_IDLE && instr_valid && q.instr_ready && q.ctrl_feat && dec_legal)
        |-> ##2 (mem_valid && !mem_write && mem_acquire == $past(acq_want, 2)))
        else $error("read acquire ordering wrong");

    a_rel_write: assert property (
        @(posedge pclk iff clk_en) disable iff (!presetn)
        (mem_valid && mem_write) |-> (mem_release == q.rel && !mem_acquire && mem_lock))
        else $error("write release ordering wrong");

    a_plain_order: assert property (
        @(posedge pclk iff clk_en) disable iff (!presetn)
        (mem_valid && !q.acq && !q.rel) |-> (!mem_acquire && !mem_release))
        else $error("ordering attached to plain access");

    a_sp_base: assert property (
        @(posedge pclk iff clk_en) disable iff (!presetn)
        (q.state == ST_FETCH && q.base_f == 5'h1F)
        |=> (sp_check && mem_addr == $past(stack_ptr) && !mem_tagchecked))
        else $error("stack pointer base handling wrong");

    a_tag_check: assert property (
        @(posedge pclk iff clk_en) disable iff (!presetn)
        mem_valid |-> (mem_tagchecked == (q.base_f != 5'h1F)))
        else $error("tag-check marking wrong");

    a_no_zero_wb: assert property (
        @(posedge pclk iff clk_en) disable iff (!presetn)
        wb_valid |-> (wb_dest != 5'h1F && (wb_is64 || wb_data[63:32] == 32'h0)))
        else $error("write-back to register 31 or not zero-extended");

    a_narrow_ext: assert property (
        @(posedge pclk iff clk_en) disable iff (!presetn)
        (mem_valid && mem_write && q.size == 2'h0) |-> (mem_wdata[63:8] == 56'h0))
        else $error("byte operand not confined to 8 bits");

    a_undef_feat: assert property (
        @(posedge pclk iff clk_en) disable iff (!presetn)
        (q.state == ST_IDLE && instr_valid && q.instr_ready && !q.ctrl_feat)
        |=> (undef_instr && q.state == ST_IDLE && !mem_valid))
        else $error("instruction accepted without atomics feature");

endmodule

// [src/aumu_pkg.sv]
// Package of constants, types and helpers for the atomic unsigned min/max unit
// Notes on behaviour
// - Minimum forms read memory, compare unsigned, write back the smaller value
// - The value read before the update is the instruction result
// - Acquire on the read when acquire bit set and destination is not 31
// - Release bit set makes the write carry release ordering
// - Neither bit set means no acquire and no release on the access
// - Operand width is eight shifted by size; size 10 is 32-bit, 11 is 64-bit
// - Byte form uses 8-bit operands and zero-extends the result to 32 bits
// - Halfword form uses 16-bit operands and zero-extends the result to 32 bits
// - Result is zero-extended to register width; no write for destination 31
// - Base 31 means stack pointer address plus alignment check, else full register
// - Access is tag-checked only when the base field is not 31
// - Acquire clear with destination 31 updates memory and returns nothing
// - Compared operand comes from the source field at the data width
// - Compare-and-swap operand is meaningless here and may take any value
// - Maximum forms write back the larger value, compared unsigned; the unit decodes only the halfword maximum form, the others are undefined
package aumu_pkg;

    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_IRQ_STATUS = 12'h008;
    localparam logic [11:0] REG_IRQ_MASK = 12'h00C;
    localparam logic [11:0] REG_OP_COUNT = 12'h010;

    localparam int CTRL_FEAT_POS = 0;
    localparam logic CTRL_FEAT_RESET = 1'b1;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    localparam int EV_DONE_POS = 0;
    localparam int EV_UNDEF_POS = 1;
    localparam int EV_SPCHK_POS = 2;

    localparam int SIZE_LO = 30;
    localparam int ACQ_POS = 23;
    localparam int REL_POS = 22;
    localparam int ONE_POS = 21;
    localparam int SRC_LO = 16;
    localparam int ZERO_POS = 15;
    localparam int OPC_LO = 12;
    localparam int BASE_LO = 5;
    localparam int DEST_LO = 0;
    localparam logic [5:0] FIXED_29_24 = 6'h38;
    localparam logic [1:0] FIXED_11_10 = 2'h0;
    localparam logic [2:0] OPC_MIN = 3'h7;
    localparam logic [2:0] OPC_MAX = 3'h6;
    localparam logic [4:0] ZERO_REG = 5'h1F;

    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_DWORD = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_READ, ST_RWAIT, ST_WRITE
    } aumu_state_type;

    function automatic logic [63:0] aumu_width_mask(input logic [1:0] sz);
        case (sz)
            2'h0: aumu_width_mask = 64'h0000_0000_0000_00FF;
            2'h1: aumu_width_mask = 64'h0000_0000_0000_FFFF;
            2'h2: aumu_width_mask = 64'h0000_0000_FFFF_FFFF;
            default: aumu_width_mask = 64'hFFFF_FFFF_FFFF_FFFF;
        endcase
    endfunction

endpackage

// [verification/aumu_mem_model.sv]
// Memory model that answers the locked read and write of each atomic operation
`timescale 1ns/1ps
module aumu_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_valid,
    input wire logic mem_write,
    input wire logic [63:0] mem_wdata,
    input wire logic [1:0] delay,
    input wire logic load,
    input wire logic [63:0] load_value,
    output logic mem_ready,
    output logic mem_rvalid,
    output logic [63:0] mem_rdata,
    output logic [63:0] mem_value
);
    logic [1:0] wait_cnt;
    // Read data toggles every cycle outside the response pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ready <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata <= 64'h0;
            mem_value <= 64'h0;
            wait_cnt <= 2'h0;
        end else begin
            mem_rvalid <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (load) begin
                mem_value <= load_value;
            end
            if (mem_valid && mem_ready) begin
                mem_ready <= 1'b0;
                wait_cnt <= 2'h0;
                if (mem_write) begin
                    mem_value <= mem_wdata;
                end else begin
                    mem_rvalid <= 1'b1;
                    mem_rdata <= mem_value;
                end
            end else if (mem_valid) begin
                if (wait_cnt == delay) begin
                    mem_ready <= 1'b1;
                end else begin
                    wait_cnt <= wait_cnt + 2'h1;
                end
            end
        end
    end
endmodule

// [verification/aumu_unit_test.sv]
// Self-checking bench for the atomic unsigned min/max unit
`timescale 1ns/1ps
module aumu_unit_test;
    import aumu_pkg::*;
    typedef struct {
        logic [1:0] size;
        logic acq;
        logic rel;
        logic mx;
        logic [4:0] dest;
        logic [4:0] base;
        logic [63:0] src;
        logic [63:0] mem;
        logic [63:0] wd;
        logic [63:0] wb;
    } aumu_row_type;
    localparam logic [63:0] BASE_VAL = 64'h0000_0000_4000_1000;
    localparam logic [63:0] SP_VAL = 64'h0000_0000_7FFF_FFF0;
    aumu_row_type rows [8] = '{
        '{2'h2, 0, 0, 0, 5'h03, 5'h04, 64'hFFFF_FFFF_7FFF_FFFF, 64'h8000_0001, 64'h7FFF_FFFF,
            64'h8000_0001},
        '{2'h3, 1, 1, 0, 5'h07, 5'h08, 64'hFFFF_FFFF_FFFF_FFFF, 64'h1, 64'h1, 64'h1},
        '{2'h0, 1, 0, 0, 5'h01, 5'h02, 64'h1234_5610, 64'hFFFF_FFFF_FFFF_FF90, 64'h10, 64'h90},
        '{2'h1, 0, 1, 0, 5'h0A, 5'h0B, 64'hABCD_FFFF, 64'h1234, 64'h1234, 64'h1234},
        '{2'h1, 1, 1, 1, 5'h0C, 5'h0D, 64'hFFFF_8001, 64'hF0, 64'h8001, 64'hF0},
        '{2'h2, 0, 1, 0, 5'h1F, 5'h05, 64'h5, 64'h9, 64'h5, 64'h0},
        '{2'h3, 1, 0, 0, 5'h1F, 5'h06, 64'h8000_0000_0000_0000, 64'h7, 64'h7, 64'h0},
        '{2'h3, 0, 0, 0, 5'h00, 5'h1F, 64'h3, 64'h2, 64'h2, 64'h2}
    };
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic instr_valid = 1'b0;
    logic [31:0] instr_word = 32'h0;
    logic [63:0] src_value = 64'h0;
    logic [1:0] delay = 2'h0;
    logic load = 1'b0;
    logic [63:0] load_value = 64'h0;
    logic [31:0] prdata;
    logic pready, pslverr, instr_ready, mem_valid, mem_write, mem_lock, mem_acquire;
    logic mem_release, mem_tagchecked, mem_op_max, mem_ready, mem_rvalid;
    logic wb_valid, wb_is64, sp_check, undef_instr, irq;
    logic [63:0] mem_addr, mem_wdata, mem_rdata, mem_value, wb_data;
    logic [1:0] mem_size;
    logic [4:0] wb_dest, rd_src, rd_base;
    logic wb_seen, sp_seen, undef_seen, w_rel;
    logic [69:0] wb_got;
    logic [69:0] r_info;
    logic [32:0] got;
    int mismatches = 0;
    int tests_run = 0;
    aumu_unit dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_ready(instr_ready), .rd_src_sel(rd_src),
        .rd_base_sel(rd_base),
        .src_value(src_value), .base_value(BASE_VAL), .stack_ptr(SP_VAL),
        .mem_valid(mem_valid), .mem_write(mem_write), .mem_lock(mem_lock),
        .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_compare(),
        .mem_acquire(mem_acquire), .mem_release(mem_release),
        .mem_tagchecked(mem_tagchecked), .mem_op_max(mem_op_max), .mem_ready(mem_ready),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .wb_valid(wb_valid),
        .wb_dest(wb_dest), .wb_data(wb_data), .wb_is64(wb_is64), .sp_check(sp_check),
        .undef_instr(undef_instr), .irq(irq));
    aumu_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_valid(mem_valid),
        .mem_write(mem_write), .mem_wdata(mem_wdata), .delay(delay), .load(load),
        .load_value(load_value), .mem_ready(mem_ready), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .mem_value(mem_value));
    always #5 pclk = ~pclk;
    // Captures pulses and accepted memory requests
    always @(posedge pclk) begin
        if (wb_valid === 1'b1) wb_got <= {wb_is64, wb_dest, wb_data};
        if (wb_valid === 1'b1) wb_seen <= 1'b1;
        if (sp_check === 1'b1) sp_seen <= 1'b1;
        if (undef_instr === 1'b1) undef_seen <= 1'b1;
        if (mem_valid && mem_ready && !mem_write)
            r_info <= {mem_lock, mem_acquire, mem_tagchecked, mem_op_max, mem_size,
                mem_addr};
        if (mem_valid && mem_ready && mem_write) w_rel <= mem_release;
    end
    task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) mismatches++;
        got = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] enc(input aumu_row_type r);
        return {r.size, FIXED_29_24, r.acq, r.rel, 1'b1, 5'h09, 1'b0,
            r.mx ? OPC_MAX : OPC_MIN, FIXED_11_10, r.base, r.dest};
    endfunction
    task automatic run_op(input logic [31:0] w);
        int n;
        wb_seen = 1'b0;
        sp_seen = 1'b0;
        undef_seen = 1'b0;
        instr_valid <= 1'b1;
        instr_word <= w;
        do @(posedge pclk); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
        for (n = 0; n < 40; n++) begin
            #1;
            if (instr_ready === 1'b1) break;
            @(posedge pclk);
        end
        if (n == 40) mismatches++;
        repeat (2) @(posedge pclk);
    endtask
    task automatic run_row(input aumu_row_type r);
        src_value <= r.src;
        load_value <= r.mem;
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
        run_op(enc(r));
        check("selects", {rd_src, rd_base}, {5'h09, r.base});
        check("read req", r_info, {1'b1, r.acq && r.dest != 5'h1F, r.base != 5'h1F, r.mx, r.size,
            r.base == 5'h1F ? SP_VAL : BASE_VAL});
        check("write", {w_rel, mem_value}, {r.rel, r.wd});
        check("wb", {wb_seen, wb_seen ? wb_got : 70'h0}, {r.dest != 5'h1F,
            r.dest != 5'h1F ? {r.size == 2'h3, r.dest, r.wb} : 70'h0});
        check("sp check", sp_seen, r.base == 5'h1F);
    endtask
    initial begin
        aumu_row_type r;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("ready", {instr_ready, mem_valid, irq}, 3'b100);
        apb(1'b0, REG_CTRL, 32'h0);
        check("ctrl", got, 33'h1);
        apb(1'b0, REG_IRQ_MASK, 32'h0);
        check("mask", got, 33'h0);
        apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        check("unmapped", got, 33'h1_0000_0000);
        $display("test reset done");
        for (int p = 0; p < 2; p++) begin
            delay <= p == 0 ? 2'h0 : 2'h3;
            for (int i = 0; i < 8; i++) run_row(rows[i]);
        end
        apb(1'b0, REG_OP_COUNT, 32'h0);
        check("op count", got, 33'd16);
        $display("test table done");
        for (int k = 0; k < 5; k++) begin
            r = rows[k % 3];
            r.mx = 1'b1;
            run_op(k < 3 ? enc(r) : enc(rows[0]) ^ (k == 3 ? 32'h0000_8000 : 32'h0020_0000));
            check("undef", {undef_seen, wb_seen}, 2'b10);
        end
        apb(1'b0, REG_IRQ_STATUS, 32'h0);
        apb(1'b1, REG_IRQ_MASK, 32'h1);
        run_row(rows[0]);
        check("irq set", irq, 1'b1);
        apb(1'b0, REG_IRQ_STATUS, 32'h0);
        check("status", got, 33'h1);
        repeat (2) @(posedge pclk);
        check("irq clear", irq, 1'b0);
        apb(1'b1, REG_CTRL, 32'h0);
        run_op(enc(rows[0]));
        check("feature off", {undef_seen, wb_seen, irq}, 3'b100);
        apb(1'b0, REG_IRQ_STATUS, 32'h0);
        check("status", got, 33'h2);
        apb(1'b1, REG_CTRL, 32'h1);
        undef_seen = 1'b0;
        clk_en <= 1'b0;
        instr_valid <= 1'b1;
        instr_word <= enc(rows[0]) ^ 32'h0000_8000;
        repeat (3) @(posedge pclk);
        check("frozen", {instr_ready, undef_seen, mem_valid}, 3'b100);
        instr_valid <= 1'b0;
        clk_en <= 1'b1;
        @(posedge pclk);
        run_row(rows[3]);
        $display("test irq done");
        finish_test();
    end
    initial begin
        #300000;
        mismatches++;
        finish_test();
    end
endmodule
